// ---- src/pic_top.sv ----
module pic_top (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [3:0]           ext_irq_pin,
  input  wire pic_pkg::pic_event_type events,
  input  wire logic                 instr_done,
  input  wire logic                 software_break_op,
  input  wire logic                 interrupt_return_op,
  input  wire logic                 enable_irq_op,
  input  wire logic [15:0]          return_pc,
  input  wire logic [7:0]           pop_data,
  output logic                      accepting,
  output logic                      push_strobe,
  output logic      [7:0]           push_data,
  output logic                      pop_strobe,
  output logic                      pc_load,
  output logic      [3:0]           vector_num,
  output logic      [7:0]           stack_pointer,
  output logic      [7:0]           processor_status_word
);
  import pic_pkg::*;

  pic_state_type     state_reg;
  logic [2:0]        cnt_reg;
  logic [NSRC-1:0]   req_reg;
  logic [NSRC-1:0]   req_next;
  logic [NSRC-1:0]   en_reg;
  logic [7:0]        edge_select_reg;
  logic [7:0]        psw_reg;
  logic [7:0]        sp_reg;
  logic [3:0]        pin_s1_reg;
  logic [3:0]        pin_s2_reg;
  logic [3:0]        pin_prev_reg;
  logic [MC_DIV_W-1:0] mc_cnt_reg;
  logic              mc_en;
  logic [3:0]        ext_edge;
  logic [NSRC-1:0]   set_vec;
  logic [NSRC-1:0]   ready_vec;
  logic              win_ok;
  logic [3:0]        win_idx;
  logic              brk_pend_reg;
  logic              hold_reg;
  logic              acc_start;
  logic              acc_brk;
  logic              brk_cur_reg;
  logic [3:0]        win_cur_reg;
  logic [15:0]       pc_save_reg;
  logic [7:0]        psw_save_reg;
  logic              first_pop_reg;
  logic              apb_wr;
  logic [7:0]        enable_high_reg;
  logic [7:0]        enable_low_reg;
  logic [7:0]        request_high_reg;
  logic [7:0]        request_low_reg;

  // Edge detect per pin according to its two-bit mode
  function automatic logic edge_hit(input logic [1:0] mode,
                                    input logic now, input logic prev);
    edge_hit = ((mode == EDGE_FALL) && prev && !now) ||
               ((mode == EDGE_RISE) && !prev && now) ||
               ((mode == EDGE_BOTH) && (prev != now));
  endfunction

  // Lowest index wins: this is the fixed priority ladder
  function automatic logic [4:0] pri_enc(input logic [NSRC-1:0] v);
    pri_enc = 5'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        pri_enc = {1'b1, 4'(i)};
      end
    end
  endfunction

  assign enable_high_reg  = en_reg[HI_W-1:0];
  assign enable_low_reg   = {1'b0, en_reg[NSRC-1:HI_W]};
  assign request_high_reg = req_reg[HI_W-1:0];
  assign request_low_reg  = {1'b0, req_reg[NSRC-1:HI_W]};

  // Two-stage pin synchroniser, prev stage only for edge compare
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
    end else begin
      pin_s1_reg <= ext_irq_pin;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Machine cycle divider; edges only sampled on its enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mc_cnt_reg   <= '0;
      pin_prev_reg <= 4'h0;
    end else begin
      mc_cnt_reg <= mc_cnt_reg + 1'b1;
      if (mc_en) begin
        pin_prev_reg <= pin_s2_reg;
      end
    end
  end
  assign mc_en = (mc_cnt_reg == '0);

  // Event collection into one set vector
  always_comb begin
    set_vec = '0;
    for (int p = 0; p < 4; p++) begin
      ext_edge[p] = mc_en && edge_hit(edge_select_reg[2*p+:2],
                                      pin_s2_reg[p], pin_prev_reg[p]);
      set_vec[SRC_EXT0+p] = ext_edge[p];
      set_vec[SRC_TMR0+p] = events.timer_match[p];
    end
    set_vec[SRC_RX]   = events.rx_done;
    set_vec[SRC_TX]   = events.tx_done;
    set_vec[SRC_SIO]  = events.sio_done;
    set_vec[SRC_ADC]  = events.conv_done;
    set_vec[SRC_WDTA] = events.wdt_match;
    set_vec[SRC_WDTB] = events.wdt_match;
    set_vec[SRC_BIT]  = events.interval_ovf;
  end

  // Gating and arbitration; break exempt from mask
  assign ready_vec = req_reg & en_reg
                   & {NSRC{psw_reg[IFLAG_BIT]}};
  assign {win_ok, win_idx} = pri_enc(ready_vec);
  assign acc_start = (state_reg == ST_IDLE) && instr_done && !hold_reg &&
                     (win_ok || brk_pend_reg);
  assign acc_brk = !win_ok; // Break is below every maskable source
  assign apb_wr = psel && penable && pready && pwrite;

  // Request flags: software write, accept clear, then set wins
  always_comb begin
    req_next = req_reg;
    if (apb_wr && paddr == OFS_REQ_HI) begin
      req_next[HI_W-1:0] = pwdata[HI_W-1:0];
    end
    if (apb_wr && paddr == OFS_REQ_LO) begin
      req_next[NSRC-1:HI_W] = pwdata[LO_W-1:0];
    end
    if (acc_start && !acc_brk) begin
      req_next[win_idx] = 1'b0;
    end
    req_next = req_next | set_vec;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_reg <= '0;
    end else begin
      req_reg <= req_next;
    end
  end

  // Software-owned configuration
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_reg          <= '0;
      edge_select_reg <= 8'h00;
    end else if (apb_wr) begin
      if (paddr == OFS_EN_HI) begin
        en_reg[HI_W-1:0] <= pwdata[HI_W-1:0];
      end
      if (paddr == OFS_EN_LO) begin
        en_reg[NSRC-1:HI_W] <= pwdata[LO_W-1:0];
      end
      if (paddr == OFS_EDGE) begin
        edge_select_reg <= pwdata[7:0];
      end
    end
  end

  // Status word; hardware accept and return override software
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      psw_reg <= PSW_RST;
    end else begin
      if (apb_wr && paddr == OFS_PSW) begin
        psw_reg <= pwdata[7:0];
      end
      if (enable_irq_op) begin
        psw_reg[IFLAG_BIT] <= 1'b1;
      end
      if (acc_start) begin
        psw_reg[IFLAG_BIT] <= 1'b0;
        psw_reg[BFLAG_BIT] <= acc_brk;
      end
      if (pop_strobe && first_pop_reg) begin
        psw_reg <= pop_data;
      end
    end
  end

  // Break pending and post-break hold-off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      brk_pend_reg <= 1'b0;
      hold_reg     <= 1'b0;
    end else begin
      if (software_break_op) begin
        brk_pend_reg <= 1'b1;
      end else if (acc_start && acc_brk) begin
        brk_pend_reg <= 1'b0;
      end
      if (state_reg == ST_ACCEPT && cnt_reg == ACC_LAST && brk_cur_reg) begin
        hold_reg <= 1'b1;
      end else if (instr_done) begin
        hold_reg <= 1'b0;
      end
    end
  end

  // Sequencer: 8-cycle acceptance, 3-pop return
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= 3'h0;
      brk_cur_reg  <= 1'b0;
      win_cur_reg  <= 4'h0;
      pc_save_reg  <= 16'h0000;
      psw_save_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= 3'h0;
          if (acc_start) begin
            state_reg    <= ST_ACCEPT;
            brk_cur_reg  <= acc_brk;
            win_cur_reg  <= win_idx;
            pc_save_reg  <= return_pc;
            psw_save_reg <= psw_reg | (acc_brk ? 8'(1 << BFLAG_BIT) : 8'h00);
          end else if (interrupt_return_op) begin
            state_reg <= ST_RETURN;
          end
        end
        ST_ACCEPT: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == ACC_LAST) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_RETURN: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == POP_LAST) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Stack traffic and vector load toward the core
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      push_strobe   <= 1'b0;
      push_data     <= 8'h00;
      pop_strobe    <= 1'b0;
      first_pop_reg <= 1'b0;
      sp_reg        <= SP_RST;
      pc_load       <= 1'b0;
      vector_num    <= 4'h0;
      accepting     <= 1'b0;
    end else begin
      push_strobe <= (state_reg == ST_ACCEPT) && (cnt_reg < PUSH_COUNT);
      case (cnt_reg)
        3'h0:    push_data <= pc_save_reg[15:8];
        3'h1:    push_data <= pc_save_reg[7:0];
        default: push_data <= psw_save_reg;
      endcase
      if ((state_reg == ST_ACCEPT) && (cnt_reg < PUSH_COUNT)) begin
        sp_reg <= sp_reg - 8'h01;
      end else if (pop_strobe) begin
        sp_reg <= sp_reg + 8'h01;
      end
      pop_strobe    <= (state_reg == ST_RETURN);
      first_pop_reg <= (state_reg == ST_RETURN) && (cnt_reg == 3'h0);
      pc_load <= (state_reg == ST_ACCEPT) && (cnt_reg == ACC_LAST);
      // Break uses the table call zero slot
      vector_num <= brk_cur_reg ? BRK_VEC : win_cur_reg + LEVEL_BASE;
      accepting  <= (state_reg == ST_ACCEPT);
    end
  end
  assign stack_pointer = sp_reg;
  assign processor_status_word = psw_reg;

  // APB slave: no wait state, pready registered so every answer comes from a flop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !pready) begin
        case (paddr)
          OFS_EN_HI:  prdata[7:0] <= enable_high_reg;
          OFS_EN_LO:  prdata[7:0] <= enable_low_reg;
          OFS_REQ_HI: prdata[7:0] <= request_high_reg;
          OFS_REQ_LO: prdata[7:0] <= request_low_reg;
          OFS_EDGE:   prdata[7:0] <= edge_select_reg;
          OFS_PSW:    prdata[7:0] <= psw_reg;
          default:    pslverr <= 1'b1; // Unmapped offset
        endcase
      end
    end
  end

  // Checks
  // Busy flag is registered from the state, so it trails the start by two
  sequence acc_busy_seq;
    accepting [*8] ##0 pc_load ##1 !accepting;
  endsequence
  property p_accept_len;
    @(posedge sys_clk) disable iff (!rst_n)
      acc_start |-> ##2 acc_busy_seq;
  endproperty
  accept_len_a: assert property (p_accept_len)
    else $error("acceptance not eight cycles");
  mask_clear_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      acc_start |=> !psw_reg[IFLAG_BIT] [*8])
    else $error("master enable not cleared on accept");
  gate_master_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      (acc_start && !psw_reg[IFLAG_BIT]) |-> acc_brk)
    else $error("maskable accepted with master enable clear");
  gate_enable_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      (acc_start && !acc_brk) |-> en_reg[win_idx] && req_reg[win_idx])
    else $error("disabled source accepted");
  push_three_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      acc_start |-> ##4 (sp_reg == $past(sp_reg, 4) - 8'h03))
    else $error("stack pointer not down by three");
  pop_three_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      (state_reg == ST_IDLE && !acc_start && interrupt_return_op)
        |-> ##5 (sp_reg == $past(sp_reg, 5) + 8'h03))
    else $error("stack pointer not up by three");
  ext_prio_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      (acc_start && ready_vec[SRC_EXT0]) |-> ##9 (vector_num == LEVEL_BASE))
    else $error("highest source not served first");
  ext_set_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      ext_edge[0] |=> req_reg[SRC_EXT0])
    else $error("edge did not set request");
  brk_flag_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      (acc_start && acc_brk) |=> psw_reg[BFLAG_BIT] ##8 (vector_num == BRK_VEC))
    else $error("break flag or vector wrong");
  flag_clear_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      (acc_start && !acc_brk && !set_vec[win_idx]) |=> !req_reg[$past(win_idx)])
    else $error("accepted flag not cleared");
endmodule // pic_top

// ---- src/pic_pkg.sv ----
package pic_pkg;
  // Source slots, index order is priority order (0 served first)
  localparam int unsigned NSRC     = 15;
  localparam int unsigned SRC_EXT0 = 0;
  localparam int unsigned SRC_RX   = 4;
  localparam int unsigned SRC_TX   = 5;
  localparam int unsigned SRC_SIO  = 6;
  localparam int unsigned SRC_TMR0 = 7;
  localparam int unsigned SRC_ADC  = 11;
  localparam int unsigned SRC_WDTA = 12;
  localparam int unsigned SRC_WDTB = 13;
  localparam int unsigned SRC_BIT  = 14;
  localparam int unsigned HI_W     = 8;
  localparam int unsigned LO_W     = 7;
  // APB byte offsets
  localparam logic [7:0] OFS_EN_HI  = 8'h00;
  localparam logic [7:0] OFS_EN_LO  = 8'h04;
  localparam logic [7:0] OFS_REQ_HI = 8'h08;
  localparam logic [7:0] OFS_REQ_LO = 8'h0C;
  localparam logic [7:0] OFS_EDGE   = 8'h10;
  localparam logic [7:0] OFS_PSW    = 8'h14;
  // Status word
  localparam int unsigned IFLAG_BIT = 2;
  localparam int unsigned BFLAG_BIT = 4;
  localparam logic [7:0]  PSW_RST   = 8'h00;
  localparam logic [7:0]  SP_RST    = 8'hFF;
  // Edge select modes, two bits per pin
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Sequencing
  localparam logic [2:0] ACC_LAST   = 3'h7;
  localparam logic [2:0] PUSH_COUNT = 3'h3;
  localparam logic [2:0] POP_LAST   = 3'h2;
  localparam logic [3:0] BRK_VEC    = 4'h0;
  localparam logic [3:0] LEVEL_BASE = 4'h2;
  localparam int unsigned MC_DIV_W  = 1;
  typedef struct packed {
    logic [3:0] timer_match;
    logic       interval_ovf;
    logic       conv_done;
    logic       wdt_match;
    logic       rx_done;
    logic       tx_done;
    logic       sio_done;
  } pic_event_type;
  typedef enum {ST_IDLE, ST_ACCEPT, ST_RETURN} pic_state_type;
endpackage

// ---- bench/pic_core_model.sv ----
// Behavioural core: stacks what the controller pushes and counts vectors
module pic_core_model #(
  parameter logic [15:0] RET_PC = 16'h3C5A
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        push_strobe,
  input  wire logic [7:0]  push_data,
  input  wire logic        pop_strobe,
  input  wire logic        pc_load,
  output logic      [15:0] return_pc,
  output logic      [7:0]  pop_data,
  output logic      [15:0] pushed_pc,
  output logic      [7:0]  pushed_psw,
  output logic      [7:0]  depth,
  output logic      [7:0]  accepts
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:15];
  logic [7:0] last_reg;
  // Only PC and status are stacked; A, X, Y stay with software
  assign return_pc = RET_PC;
  // Empty stack shows the inverse of the last byte, never a stale copy
  assign pop_data = (depth != 8'h00) ? mem[depth[3:0] - 4'h1] : ~last_reg;
  // LIFO stack, pushes hi, lo, status; pops come back reversed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      depth <= 8'h00;
      last_reg <= 8'h00;
      accepts <= 8'h00;
      pushed_pc <= 16'h0000;
      pushed_psw <= 8'h00;
    end else begin
      if (push_strobe) begin
        mem[depth[3:0]] <= push_data;
        depth <= depth + 8'h01;
        case (depth % 8'h03)
          8'h00: pushed_pc[15:8] <= push_data;
          8'h01: pushed_pc[7:0] <= push_data;
          default: pushed_psw <= push_data;
        endcase
      end
      if (pop_strobe) begin
        last_reg <= pop_data;
        depth <= depth - 8'h01;
      end
      if (pc_load) begin
        accepts <= accepts + 8'h01;
      end
    end
  end
endmodule // pic_core_model

// ---- bench/tb_prioritized_interrupt_controller.sv ----
module tb_prioritized_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ns;
  import pic_pkg::*;
  localparam logic [15:0] PC_VAL = 16'h3C5A;
  logic sys_clk = 1'b0;
  logic rst_n, psel, penable, pwrite, pready, pslverr;
  logic accepting, push_strobe, pop_strobe, pc_load;
  logic [7:0] paddr, push_data, pop_data, stack_pointer;
  logic [7:0] processor_status_word, pushed_psw, depth, accepts;
  logic [31:0] pwdata, prdata;
  logic [3:0] ext_irq_pin, op, vector_num;
  logic [15:0] return_pc, pushed_pc;
  logic [14:0] m, b;
  pic_event_type events;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  // Rows: event pulse and the source index it should be served as
  pic_event_type ev_t [11] = '{10'h004, 10'h002, 10'h001, 10'h040,
    10'h080, 10'h100, 10'h200, 10'h010, 10'h008, 10'h008, 10'h020};
  int idx_t [11] = '{4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14};

  pic_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin(ext_irq_pin), .events(events), .instr_done(op[0]),
    .software_break_op(op[1]), .interrupt_return_op(op[2]),
    .enable_irq_op(op[3]), .return_pc(return_pc), .pop_data(pop_data),
    .accepting(accepting), .push_strobe(push_strobe),
    .push_data(push_data), .pop_strobe(pop_strobe), .pc_load(pc_load),
    .vector_num(vector_num), .stack_pointer(stack_pointer),
    .processor_status_word(processor_status_word));
  pic_core_model #(.RET_PC(PC_VAL)) u_core (.sys_clk(sys_clk),
    .rst_n(rst_n), .push_strobe(push_strobe), .push_data(push_data),
    .pop_strobe(pop_strobe), .pc_load(pc_load), .return_pc(return_pc),
    .pop_data(pop_data), .pushed_pc(pushed_pc), .pushed_psw(pushed_psw),
    .depth(depth), .accepts(accepts));

  // Clock, 50 ns period
  initial forever #25 sys_clk = ~sys_clk;
  // Hang guard, far above the fewer than one thousand cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, d);
    check(e, ee);
  endtask
  task automatic pulse(input logic [3:0] k);
    @(posedge sys_clk) op <= k;
    @(posedge sys_clk) op <= 4'h0;
  endtask
  task automatic fire(input pic_event_type ev);
    @(posedge sys_clk) events <= ev;
    @(posedge sys_clk) events <= '0;
  endtask
  // Instruction end, then the full acceptance with its 8 busy cycles
  task automatic accept(input logic [3:0] v, input logic [7:0] sp);
    int n;
    int a;
    n = 0;
    a = 0;
    pulse(4'h1);
    do begin
      @(posedge sys_clk);
      n++;
      if (accepting === 1'b1) a++;
    end while (pc_load !== 1'b1 && n < 40);
    check(a, 8);
    check(pc_load, 1'b1);
    check(vector_num, v);
    check(stack_pointer, sp);
    check(pushed_pc, PC_VAL);
    check(depth, 8'hFF - sp);
    check(processor_status_word[IFLAG_BIT], 1'b0);
  endtask
  task automatic none();
    logic [7:0] c;
    c = accepts;
    pulse(4'h1);
    repeat (12) @(posedge sys_clk);
    check(accepts, c);
  endtask
  task automatic ret(input logic [7:0] sp, input logic i);
    pulse(4'h4);
    repeat (6) @(posedge sys_clk);
    check(stack_pointer, sp);
    check(depth, 8'hFF - sp);
    check(processor_status_word[IFLAG_BIT], i);
  endtask

  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ext_irq_pin = 4'h0;
    events = '0;
    op = 4'h0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Reset values, then an unmapped offset
    check(stack_pointer, SP_RST);
    for (int k = 0; k < 6; k++)
      rd(8'(4 * k), 32'h0, 1'b0);
    rd(8'h18, 32'h0, 1'b1);
    // Each event source alone: flag set, served at its level, cleared
    for (int r = 0; r < 11; r++) begin
      m = (ev_t[r] == 10'h008) ? 15'h3000 : 15'h0001 << idx_t[r];
      b = 15'h0001 << idx_t[r];
      wr(OFS_EN_HI, 32'(b[7:0]));
      wr(OFS_EN_LO, 32'(b[14:8]));
      fire(ev_t[r]);
      rd(OFS_REQ_HI, 32'(m[7:0]), 1'b0);
      rd(OFS_REQ_LO, 32'(m[14:8]), 1'b0);
      pulse(4'h8);
      accept(4'(idx_t[r] + 2), 8'hFC);
      m = m & ~b;
      rd(OFS_REQ_HI, 32'(m[7:0]), 1'b0);
      rd(OFS_REQ_LO, 32'(m[14:8]), 1'b0);
      ret(8'hFF, 1'b1);
      wr(OFS_REQ_LO, 32'h0);
    end
    // All at once: highest wins, then nesting after a fresh enable
    wr(OFS_EN_HI, 32'hFF);
    wr(OFS_EN_LO, 32'h7F);
    fire(10'h3FF);
    pulse(4'h8);
    accept(4'h6, 8'hFC);
    pulse(4'h8);
    accept(4'h7, 8'hF9);
    ret(8'hFC, 1'b1);
    ret(8'hFF, 1'b1);
    wr(OFS_PSW, 32'h0);
    none();
    pulse(4'h8);
    wr(OFS_EN_HI, 32'h0);
    wr(OFS_EN_LO, 32'h0);
    none();
    rd(OFS_REQ_HI, 32'hC0, 1'b0);
    rd(OFS_REQ_LO, 32'h7F, 1'b0);
    wr(OFS_REQ_HI, 32'h0);
    wr(OFS_REQ_LO, 32'h0);
    // Pin 0 fall, pin 1 rise, pin 2 both, pin 3 off
    wr(OFS_EDGE, 32'h39);
    ext_irq_pin <= 4'hF;
    repeat (8) @(posedge sys_clk);
    rd(OFS_REQ_HI, 32'h06, 1'b0);
    wr(OFS_REQ_HI, 32'h0);
    ext_irq_pin <= 4'h0;
    repeat (8) @(posedge sys_clk);
    rd(OFS_REQ_HI, 32'h05, 1'b0);
    wr(OFS_EN_HI, 32'h01);
    pulse(4'h8);
    accept(4'h2, 8'hFC);
    rd(OFS_REQ_HI, 32'h04, 1'b0);
    ret(8'hFF, 1'b1);
    // Break with master off, then the hold against the next request
    wr(OFS_REQ_HI, 32'h0);
    wr(OFS_PSW, 32'h0);
    pulse(4'h2);
    accept(BRK_VEC, 8'hFC);
    check(pushed_psw[BFLAG_BIT], 1'b1);
    wr(OFS_EN_HI, 32'h10);
    fire(10'h004);
    pulse(4'h8);
    none();
    accept(4'h6, 8'hF9);
    ret(8'hFC, 1'b1);
    ret(8'hFF, 1'b0);
    // Reset in the middle of an acceptance
    pulse(4'h2);
    pulse(4'h1);
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(stack_pointer, SP_RST);
    check(processor_status_word, PSW_RST);
    check(accepting, 1'b0);
    rst_n <= 1'b1;
    print_verdict();
  end
endmodule // tb_prioritized_interrupt_controller
